//--- host_model.sv
`timescale 1ns/1ns
module host_model (
  input  wire logic i_sys_clk,
  input  wire logic i_sda_wire,
  output logic      o_scl,
  output logic      o_sda_low
);
  logic acked;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
    acked = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge i_sys_clk);
    #2;
  endtask
  // Six cycles a phase keeps clear of the four-cycle minimum
  task automatic bit_io(input logic b, output logic r);
    o_sda_low = !b;
    wt(3);
    o_scl = 1'b1;
    wt(3);
    r = i_sda_wire;
    wt(3);
    o_scl = 1'b0;
    wt(3);
  endtask
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(last, r);
    ack = !r;
  endtask
  task automatic start();
    o_sda_low = 1'b0;
    wt(3);
    o_scl = 1'b1;
    wt(3);
    o_sda_low = 1'b1;
    wt(3);
    o_scl = 1'b0;
    wt(3);
  endtask
  task automatic stop();
    o_sda_low = 1'b1;
    wt(3);
    o_scl = 1'b1;
    wt(3);
    o_sda_low = 1'b0;
    wt(6);
  endtask
  task automatic write_reg(input logic [6:0] a, input logic [7:0] sub, input logic [7:0] d);
    logic [7:0] q;
    logic       k;
    start();
    xfer({a, 1'b0}, 1'b1, q, acked);
    xfer(sub, 1'b1, q, k);
    xfer(d, 1'b1, q, k);
    stop();
  endtask
  task automatic read_reg(input logic [6:0] a, input logic [7:0] sub, output logic [7:0] d);
    logic [7:0] q;
    logic       k;
    start();
    xfer({a, 1'b0}, 1'b1, q, acked);
    xfer(sub, 1'b1, q, k);
    start();
    xfer({a, 1'b1}, 1'b1, q, k);
    xfer(8'hFF, 1'b1, d, k);
    stop();
  endtask
endmodule

//--- pic_adj_properties.sv
`timescale 1ns/1ns
module pic_adj_properties (
  input wire logic                                  i_sys_clk,
  input wire logic                                  i_reset_n,
  input wire logic                                  i_scl,
  input wire logic                                  i_sda,
  input wire logic                                  i_gain_pivot_select,
  input wire logic [4:0]                            i_status_other,
  input wire picture_adjust_pkg::pixel_type         i_pixel,
  input wire picture_adjust_pkg::decode_result_type i_decoded,
  input wire logic                                  o_sda_out,
  input wire logic                                  o_sda_oe,
  input wire logic [2:0]                            o_decode_request,
  input wire picture_adjust_pkg::pixel_type         o_pixel
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_reset_n);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_sample_in;
    i_pixel.valid;
  endsequence
  sequence s_sample_out;
    ##3 o_pixel.valid;
  endsequence
  a_pixel_latency: assert property (s_sample_in |-> s_sample_out)
    else $error("output sample missing three cycles after input");
  a_valid_cause: assert property (o_pixel.valid |-> $past(i_pixel.valid, 3))
    else $error("output sample without input");
  a_pixel_hold: assert property (!o_pixel.valid |-> $stable({o_pixel.luma, o_pixel.cb, o_pixel.cr}))
    else $error("output sample changed between strobes");
  ////////////////////////////////////////////////////////////////////////////////
  a_request_clear: assert property ((o_decode_request & i_decoded.done) != 3'h0 |=>
      (o_decode_request & $past(i_decoded.done)) == 3'h0)
    else $error("request still pending after completion");
  a_request_hold: assert property
      (($past(o_decode_request) & ~o_decode_request & ~$past(i_decoded.done)) == 3'h0)
    else $error("request dropped without completion");
  a_request_rise: assert property
      ((o_decode_request & ~$past(o_decode_request)) != 3'h0 |-> !i_scl)
    else $error("request raised outside a register write");
  ////////////////////////////////////////////////////////////////////////////////
  // Data may only move while the serial clock is low
  a_oe_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data line moved with serial clock high");
  a_oe_hold: assert property ($rose(o_sda_oe) |=> o_sda_oe [*8])
    else $error("data line released too early");
  a_sda_low_only: assert property (o_sda_out == 1'b0)
    else $error("open drain output driven high");
endmodule
bind picture_adjust_vbi_request_regs pic_adj_properties pic_adj_properties_i (
  .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_scl(i_scl), .i_sda(i_sda),
  .i_gain_pivot_select(i_gain_pivot_select), .i_status_other(i_status_other),
  .i_pixel(i_pixel), .i_decoded(i_decoded), .o_sda_out(o_sda_out),
  .o_sda_oe(o_sda_oe), .o_decode_request(o_decode_request), .o_pixel(o_pixel));

//--- picture_adjust_defines.svh
`ifndef PICTURE_ADJUST_DEFINES_SVH
`define PICTURE_ADJUST_DEFINES_SVH
`define ADDR_LUMA_GAIN        8'h06
`define ADDR_LUMA_OFFSET      8'h07
`define ADDR_CHROMA_INTENSITY 8'h08
`define ADDR_CHROMA_PHASE     8'h09
`define ADDR_BLANKING_REQUEST 8'h0A
`define ADDR_SKEW             8'h0B
`define ADDR_STATUS           8'h10
`define ADDR_CAPTION_LO       8'h12
`define ADDR_CAPTION_HI       8'h13
`define ADDR_AUX_LO           8'h14
`define ADDR_AUX_HI           8'h15
`define ADDR_COPY_LO          8'h16
`define ADDR_COPY_HI          8'h17
`define RST_LUMA_GAIN         8'h80
`define RST_LUMA_OFFSET       8'h00
`define RST_CHROMA_INTENSITY  8'h80
`define RST_CHROMA_PHASE      8'h00
`define RST_SKEW              3'h0
`define PIVOT_MID             8'h80
`define PIVOT_BLACK           8'h10
`define CHROMA_ZERO           12'h080
`define HUE_STEP_Q12          13'h0019
`define ONE_Q12               14'h1000
`define SIXTH_Q12             12'h2AB
`endif

//--- picture_adjust_pkg.sv
package picture_adjust_pkg;
  typedef struct packed {
    logic       valid;
    logic [7:0] luma;
    logic [7:0] cb;
    logic [7:0] cr;
  } pixel_type;
  // done[0] caption, done[1] auxiliary caption, done[2] copy guard
  typedef struct packed {
    logic [2:0]  done;
    logic [15:0] caption_data;
    logic [15:0] aux_data;
    logic [15:0] copy_data;
  } decode_result_type;
  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_ADDR      = 4'h1,
    ST_ADDR_ACK  = 4'h3,
    ST_SUB       = 4'h2,
    ST_SUB_ACK   = 4'h6,
    ST_WRITE     = 4'h7,
    ST_WRITE_ACK = 4'h5,
    ST_READ      = 4'hB,
    ST_READ_ACK  = 4'hA
  } serial_state_type;
endpackage

//--- picture_adjust_vbi_request_regs.sv
`timescale 1ns/1ns
`include "picture_adjust_defines.svh"

module picture_adjust_vbi_request_regs #(
  parameter logic [6:0] DEVICE_ADDRESS = 7'h21, // Arbitrary value
  parameter int         SKEW_STAGES    = 3
) (
  input  wire logic                                  i_sys_clk,
  input  wire logic                                  i_reset_n,
  input  wire logic                                  i_scl,
  input  wire logic                                  i_sda,
  input  wire logic                                  i_gain_pivot_select,
  input  wire logic [4:0]                            i_status_other,
  input  wire picture_adjust_pkg::pixel_type         i_pixel,
  input  wire picture_adjust_pkg::decode_result_type i_decoded,
  output logic                                       o_sda_out,
  output logic                                       o_sda_oe,
  output logic [2:0]                                 o_decode_request,
  output picture_adjust_pkg::pixel_type              o_pixel
);

  ////////////////////////////////////////////////////////////////////////////
  logic [1:0]                           scl_sync;
  logic [1:0]                           sda_sync;
  logic                                 scl_prev;
  logic                                 sda_prev;
  logic                                 scl;
  logic                                 sda;
  logic                                 start_seen;
  logic                                 stop_seen;
  logic                                 scl_rise;
  logic                                 scl_fall;
  picture_adjust_pkg::serial_state_type state;
  logic [3:0]                           bit_cnt;
  logic [7:0]                           shreg;
  logic [7:0]                           tx_byte;
  logic [7:0]                           sub_addr;
  logic                                 read_mode;
  logic                                 master_nack;
  logic                                 wr_en;
  logic [7:0]                           wr_addr;
  logic [7:0]                           wr_data;
  logic [7:0]                           rd_byte;

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], i_scl};
      sda_sync <= {sda_sync[0], i_sda};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  assign scl        = scl_sync[1];
  assign sda        = sda_sync[1];
  assign start_seen = scl && scl_prev && sda_prev && !sda;
  assign stop_seen  = scl && scl_prev && !sda_prev && sda;
  assign scl_rise   = scl && !scl_prev;
  assign scl_fall   = !scl && scl_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Serial slave: data changes only while the clock line is low
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state       <= picture_adjust_pkg::ST_IDLE;
      bit_cnt     <= 4'h0;
      shreg       <= 8'h00;
      tx_byte     <= 8'h00;
      sub_addr    <= 8'h00;
      read_mode   <= 1'b0;
      master_nack <= 1'b0;
      wr_en       <= 1'b0;
      wr_addr     <= 8'h00;
      wr_data     <= 8'h00;
      o_sda_oe    <= 1'b0;
      o_sda_out   <= 1'b0;
    end else begin
      wr_en     <= 1'b0;
      o_sda_out <= 1'b0;
      if (start_seen) begin
        state    <= picture_adjust_pkg::ST_ADDR;
        bit_cnt  <= 4'h0;
        o_sda_oe <= 1'b0;
      end else if (stop_seen) begin
        state    <= picture_adjust_pkg::ST_IDLE;
        o_sda_oe <= 1'b0;
      end else if (scl_rise) begin
        case (state)
          picture_adjust_pkg::ST_ADDR,
          picture_adjust_pkg::ST_SUB,
          picture_adjust_pkg::ST_WRITE: begin
            shreg   <= {shreg[6:0], sda};
            bit_cnt <= bit_cnt + 4'h1;
          end
          picture_adjust_pkg::ST_READ_ACK: master_nack <= sda;
          default: ;
        endcase
      end else if (scl_fall) begin
        case (state)
          picture_adjust_pkg::ST_ADDR: begin
            if (bit_cnt == 4'h8) begin
              bit_cnt <= 4'h0;
              if (shreg[7:1] == DEVICE_ADDRESS) begin
                state     <= picture_adjust_pkg::ST_ADDR_ACK;
                read_mode <= shreg[0];
                o_sda_oe  <= 1'b1;
              end else begin
                state <= picture_adjust_pkg::ST_IDLE;
              end
            end
          end
          picture_adjust_pkg::ST_ADDR_ACK, picture_adjust_pkg::ST_READ_ACK: begin
            if (state == picture_adjust_pkg::ST_READ_ACK && master_nack) begin
              state    <= picture_adjust_pkg::ST_IDLE;
              o_sda_oe <= 1'b0;
            end else if (state == picture_adjust_pkg::ST_READ_ACK || read_mode) begin
              state    <= picture_adjust_pkg::ST_READ;
              o_sda_oe <= ~rd_byte[7];
              tx_byte  <= {rd_byte[6:0], 1'b0};
              bit_cnt  <= 4'h1;
              sub_addr <= sub_addr + 8'h01;
            end else begin
              state    <= picture_adjust_pkg::ST_SUB;
              o_sda_oe <= 1'b0;
            end
          end
          picture_adjust_pkg::ST_SUB: begin
            if (bit_cnt == 4'h8) begin
              state    <= picture_adjust_pkg::ST_SUB_ACK;
              sub_addr <= shreg;
              bit_cnt  <= 4'h0;
              o_sda_oe <= 1'b1;
            end
          end
          picture_adjust_pkg::ST_SUB_ACK: begin
            state    <= picture_adjust_pkg::ST_WRITE;
            o_sda_oe <= 1'b0;
          end
          picture_adjust_pkg::ST_WRITE: begin
            if (bit_cnt == 4'h8) begin
              state    <= picture_adjust_pkg::ST_WRITE_ACK;
              wr_en    <= 1'b1;
              wr_addr  <= sub_addr;
              wr_data  <= shreg;
              bit_cnt  <= 4'h0;
              o_sda_oe <= 1'b1;
            end
          end
          picture_adjust_pkg::ST_WRITE_ACK: begin
            state    <= picture_adjust_pkg::ST_WRITE;
            sub_addr <= sub_addr + 8'h01;
            o_sda_oe <= 1'b0;
          end
          picture_adjust_pkg::ST_READ: begin
            if (bit_cnt == 4'h8) begin
              state    <= picture_adjust_pkg::ST_READ_ACK;
              o_sda_oe <= 1'b0;
            end else begin
              o_sda_oe <= ~tx_byte[7];
              tx_byte  <= {tx_byte[6:0], 1'b0};
              bit_cnt  <= bit_cnt + 4'h1;
            end
          end
          default: state <= picture_adjust_pkg::ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]  luma_gain;
  logic [7:0]  luma_offset;
  logic [7:0]  chroma_intensity;
  logic [7:0]  chroma_phase_rotation;
  logic [2:0]  luma_chroma_skew_code;
  logic [2:0]  ready_flags;
  logic [15:0] caption_result;
  logic [15:0] aux_result;
  logic [15:0] copy_result;
  logic [2:0]  request_bits;
  logic [2:0]  accepted;

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      luma_gain             <= `RST_LUMA_GAIN;
      luma_offset           <= `RST_LUMA_OFFSET;
      chroma_intensity      <= `RST_CHROMA_INTENSITY;
      chroma_phase_rotation <= `RST_CHROMA_PHASE;
      luma_chroma_skew_code <= `RST_SKEW;
    end else if (wr_en) begin
      case (wr_addr)
        `ADDR_LUMA_GAIN:        luma_gain <= wr_data;
        `ADDR_LUMA_OFFSET:      luma_offset <= wr_data;
        `ADDR_CHROMA_INTENSITY: chroma_intensity <= wr_data;
        `ADDR_CHROMA_PHASE:     chroma_phase_rotation <= wr_data;
        `ADDR_SKEW:             luma_chroma_skew_code <= wr_data[2:0];
        default: ;
      endcase
    end
  end

  // Only ones in bits 2:0 count; reserved bits are dropped
  assign request_bits = (wr_en && wr_addr == `ADDR_BLANKING_REQUEST) ? wr_data[2:0] : 3'h0;
  // Results are taken only for an item that is still waiting
  assign accepted     = i_decoded.done & o_decode_request;

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_decode_request <= 3'h0;
      ready_flags      <= 3'h0;
    end else begin
      o_decode_request <= (o_decode_request & ~accepted) | request_bits;
      // A completion in the clearing cycle still sets its flag
      ready_flags <= ((|request_bits) ? 3'h0 : ready_flags) | accepted;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      caption_result <= 16'h0000;
      aux_result     <= 16'h0000;
      copy_result    <= 16'h0000;
    end else begin
      if (accepted[0]) caption_result <= i_decoded.caption_data;
      if (accepted[1]) aux_result <= i_decoded.aux_data;
      if (accepted[2]) copy_result <= i_decoded.copy_data;
    end
  end

  always_comb begin
    case (sub_addr)
      `ADDR_LUMA_GAIN:        rd_byte = luma_gain;
      `ADDR_LUMA_OFFSET:      rd_byte = luma_offset;
      `ADDR_CHROMA_INTENSITY: rd_byte = chroma_intensity;
      `ADDR_CHROMA_PHASE:     rd_byte = chroma_phase_rotation;
      `ADDR_SKEW:             rd_byte = {5'h00, luma_chroma_skew_code};
      `ADDR_STATUS:           rd_byte = {ready_flags[2:0], i_status_other};
      `ADDR_CAPTION_LO:       rd_byte = caption_result[7:0];
      `ADDR_CAPTION_HI:       rd_byte = caption_result[15:8];
      `ADDR_AUX_LO:           rd_byte = aux_result[7:0];
      `ADDR_AUX_HI:           rd_byte = aux_result[15:8];
      `ADDR_COPY_LO:          rd_byte = copy_result[7:0];
      `ADDR_COPY_HI:          rd_byte = copy_result[15:8];
      default:                rd_byte = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stage 1: luma gain about a pivot plus offset, chroma amplitude
  logic [7:0]         pivot;
  logic signed [9:0]  luma_diff;
  logic signed [18:0] luma_prod;
  logic signed [11:0] luma_sum;
  logic signed [8:0]  cb_diff;
  logic signed [8:0]  cr_diff;
  logic signed [17:0] cb_prod;
  logic signed [17:0] cr_prod;
  logic               s1_valid;
  logic [7:0]         s1_luma;
  logic signed [10:0] s1_u;
  logic signed [10:0] s1_v;

  function automatic logic [7:0] clamp8(input logic signed [11:0] value);
    if (value < 12'sh000)
      clamp8 = 8'h00;
    else if (value > 12'sh0FF)
      clamp8 = 8'hFF;
    else
      clamp8 = value[7:0];
  endfunction

  assign pivot     = i_gain_pivot_select ? `PIVOT_BLACK : `PIVOT_MID;
  assign luma_diff = $signed({2'b00, i_pixel.luma}) - $signed({2'b00, pivot});
  assign luma_prod = luma_diff * $signed({1'b0, luma_gain});
  assign luma_sum  = luma_prod[18:7] + $signed({4'h0, pivot})
                   + {{4{luma_offset[7]}}, luma_offset};
  assign cb_diff   = $signed({1'b0, i_pixel.cb}) - 9'sh080;
  assign cr_diff   = $signed({1'b0, i_pixel.cr}) - 9'sh080;
  // Zero factor collapses both components to the neutral level
  assign cb_prod   = cb_diff * $signed({1'b0, chroma_intensity});
  assign cr_prod   = cr_diff * $signed({1'b0, chroma_intensity});

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s1_valid <= 1'b0;
      s1_luma  <= 8'h00;
      s1_u     <= 11'sh000;
      s1_v     <= 11'sh000;
    end else begin
      s1_valid <= i_pixel.valid;
      if (i_pixel.valid) begin
        s1_luma <= clamp8(luma_sum);
        s1_u    <= cb_prod[17:7];
        s1_v    <= cr_prod[17:7];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stage 2: phase rotation; third-order sine and second-order cosine
  // keep the gain error near one percent at the full 45 degrees.
  logic signed [12:0] theta;
  logic signed [25:0] theta_sq;
  logic signed [26:0] theta_cube;
  logic signed [24:0] cube_sixth;
  logic signed [13:0] cos_q12;
  logic signed [13:0] sin_q12;
  logic signed [25:0] rot_u;
  logic signed [25:0] rot_v;
  logic               s2_valid;

  logic [7:0]  y_tap [0:SKEW_STAGES];
  logic [15:0] c_tap [0:SKEW_STAGES];

  assign theta      = 13'($signed(chroma_phase_rotation) * $signed(`HUE_STEP_Q12));
  assign theta_sq   = theta * theta;
  assign theta_cube = $signed({1'b0, theta_sq[24:12]}) * theta;
  // Part-select drops the sign; restore it so negative hue rotates back
  assign cube_sixth = $signed(theta_cube[24:12]) * $signed(`SIXTH_Q12);
  assign cos_q12    = $signed(`ONE_Q12) - $signed({2'b00, theta_sq[24:13]});
  assign sin_q12    = {theta[12], theta} - {cube_sixth[24], cube_sixth[24:12]};
  assign rot_u      = s1_u * cos_q12 - s1_v * sin_q12;
  assign rot_v      = s1_u * sin_q12 + s1_v * cos_q12;

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s2_valid <= 1'b0;
      y_tap[0] <= 8'h00;
      c_tap[0] <= 16'h8080;
    end else begin
      s2_valid <= s1_valid;
      if (s1_valid) begin
        y_tap[0] <= s1_luma;
        c_tap[0] <= {clamp8({rot_u[22], rot_u[22:12]} + `CHROMA_ZERO),
                     clamp8({rot_v[22], rot_v[22:12]} + `CHROMA_ZERO)};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One skew step is one incoming sample, so its length follows the
  // rate of the i_pixel.valid strobes.
  logic [1:0] y_sel;
  logic [1:0] c_sel;

  generate
    for (genvar k = 1; k <= SKEW_STAGES; k++) begin : g_skew
      always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          y_tap[k] <= 8'h00;
          c_tap[k] <= 16'h8080;
        end else if (s2_valid) begin
          y_tap[k] <= y_tap[k-1];
          c_tap[k] <= c_tap[k-1];
        end
      end
    end
  endgenerate

  always_comb begin
    y_sel = 2'h0;
    c_sel = 2'h0;
    case (luma_chroma_skew_code)
      3'h5: y_sel = 2'h3;
      3'h6: y_sel = 2'h2;
      3'h7: y_sel = 2'h1;
      3'h1: c_sel = 2'h1;
      3'h2: c_sel = 2'h2;
      3'h3: c_sel = 2'h3;
      default: ;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pixel <= '{valid: 1'b0, luma: 8'h00, cb: 8'h80, cr: 8'h80};
    end else begin
      o_pixel.valid <= s2_valid;
      if (s2_valid) begin
        o_pixel.luma         <= y_tap[y_sel];
        {o_pixel.cb, o_pixel.cr} <= c_tap[c_sel];
      end
    end
  end

endmodule

//--- tb_top.sv
`timescale 1ns/1ns
`include "picture_adjust_defines.svh"
module tb_top;
  localparam logic [6:0] DEV = 7'h21; // Arbitrary value, same as the design
  logic                                  clk;
  logic                                  i_reset_n;
  logic                                  scl;
  logic                                  host_low;
  logic                                  sda_wire;
  logic                                  pivot;
  logic [4:0]                            status_other;
  picture_adjust_pkg::pixel_type         pixel_in;
  picture_adjust_pkg::pixel_type         pixel_out;
  picture_adjust_pkg::pixel_type         pout;
  picture_adjust_pkg::decode_result_type decoded;
  logic                                  sda_out;
  logic                                  sda_oe;
  logic [2:0]                            request;
  int                                    err_total = 0;
  int                                    check_count = 0;
  int                                    cycles = 0;
  // Pulled-up open-drain line
  assign sda_wire = !(host_low || sda_oe);
  picture_adjust_vbi_request_regs picture_adjust_vbi_request_regs_i (
    .i_sys_clk(clk), .i_reset_n(i_reset_n), .i_scl(scl), .i_sda(sda_wire),
    .i_gain_pivot_select(pivot), .i_status_other(status_other), .i_pixel(pixel_in),
    .i_decoded(decoded), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
    .o_decode_request(request), .o_pixel(pixel_out));
  host_model host_model_i (.i_sys_clk(clk), .i_sda_wire(sda_wire), .o_scl(scl),
    .o_sda_low(host_low));
  initial begin
    clk = 1'b0;
    forever #25 clk = !clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] sub, input logic [7:0] d);
    host_model_i.write_reg(DEV, sub, d);
  endtask
  task automatic chk_reg(input logic [7:0] sub, input logic [7:0] exp);
    logic [7:0] q;
    host_model_i.read_reg(DEV, sub, q);
    check($sformatf("register %h", sub), {8'h00, q}, {8'h00, exp});
  endtask
  task automatic pix(input logic [7:0] y, input logic [7:0] cb, input logic [7:0] cr);
    pixel_in = '{1'b1, y, cb, cr};
    @(posedge clk);
    #2 pixel_in.valid = 1'b0;
    repeat (2) @(posedge clk);
    #2 pout = pixel_out;
    check("output strobe", {15'h0, pout.valid}, 16'h0001);
  endtask
  task automatic pulse(input logic [2:0] done, input logic [15:0] d);
    decoded = '{done, d, d, d};
    @(posedge clk);
    #2 decoded.done = 3'h0;
    @(posedge clk);
    #2;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] exp [6] = '{8'h80, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 6; i++) begin
      chk_reg(8'(`ADDR_LUMA_GAIN + i), exp[i]);
    end
    chk_reg(`ADDR_STATUS, {3'b000, status_other});
  endtask
  task automatic t_regs();
    logic [7:0] val [4] = '{8'hA5, 8'h5A, 8'h3C, 8'hC3};
    for (int i = 0; i < 4; i++) begin
      wr(8'(`ADDR_LUMA_GAIN + i), val[i]);
      chk_reg(8'(`ADDR_LUMA_GAIN + i), val[i]);
    end
    wr(`ADDR_SKEW, 8'hFF);
    chk_reg(`ADDR_SKEW, 8'h07);
    // Foreign address must be left alone
    host_model_i.write_reg(DEV ^ 7'h01, `ADDR_LUMA_GAIN, 8'h11);
    check("foreign ack", {15'h0, host_model_i.acked}, 16'h0000);
    chk_reg(`ADDR_LUMA_GAIN, 8'hA5);
  endtask
  task automatic t_video();
    wr(`ADDR_SKEW, 8'h00);
    wr(`ADDR_LUMA_GAIN, 8'h40);
    wr(`ADDR_LUMA_OFFSET, 8'h10);
    wr(`ADDR_CHROMA_INTENSITY, 8'h00);
    wr(`ADDR_CHROMA_PHASE, 8'h20);
    pix(8'h40, 8'hC0, 8'h30);
    check("luma mid pivot", {8'h00, pout.luma}, 16'h0070);
    check("colourless", {pout.cb, pout.cr}, 16'h8080);
    pivot = 1'b1;
    pix(8'h50, 8'hC0, 8'h30);
    check("luma black pivot", {8'h00, pout.luma}, 16'h0040);
    pivot = 1'b0;
    wr(`ADDR_LUMA_GAIN, 8'h80);
    wr(`ADDR_LUMA_OFFSET, 8'hF0);
    wr(`ADDR_CHROMA_INTENSITY, 8'h80);
    wr(`ADDR_CHROMA_PHASE, 8'h00);
    pix(8'h50, 8'hC0, 8'h30);
    check("luma offset", {8'h00, pout.luma}, 16'h0040);
    check("chroma unity", {pout.cb, pout.cr}, 16'hC030);
    // About 11 degrees either way: u 64 -> 62.8, v 0 -> +/-12.4, truncated
    wr(`ADDR_CHROMA_PHASE, 8'h20);
    pix(8'h50, 8'hC0, 8'h80);
    check("hue plus", {pout.cb, pout.cr}, 16'hBE8C);
    wr(`ADDR_CHROMA_PHASE, 8'hE0);
    pix(8'h50, 8'hC0, 8'h80);
    check("hue minus", {pout.cb, pout.cr}, 16'hBE73);
    wr(`ADDR_CHROMA_PHASE, 8'h00);
    wr(`ADDR_LUMA_OFFSET, 8'h00);
  endtask
  task automatic t_skew();
    logic [2:0] code [6] = '{3'h5, 3'h6, 3'h7, 3'h1, 3'h2, 3'h3};
    int         dl [6] = '{3, 2, 1, 0, 0, 0};
    int         dc [6] = '{0, 0, 0, 1, 2, 3};
    for (int k = 0; k < 6; k++) begin
      wr(`ADDR_SKEW, {5'h00, code[k]});
      for (int n = 0; n < 7; n++) begin
        pix(8'(32 + n * 8), 8'(96 + n * 4), 8'(160 - n * 4));
        if (n >= 3) begin
          check("skew luma", {8'h00, pout.luma}, 16'(32 + (n - dl[k]) * 8));
          check("skew chroma", {8'h00, pout.cb}, 16'(96 + (n - dc[k]) * 4));
        end
      end
    end
    wr(`ADDR_SKEW, 8'h00);
  endtask
  task automatic t_request();
    wr(`ADDR_BLANKING_REQUEST, 8'h01);
    check("request", {13'h0000, request}, 16'h0001);
    pulse(3'b001, 16'hA55A);
    check("request done", {13'h0000, request}, 16'h0000);
    chk_reg(`ADDR_STATUS, {3'b001, status_other});
    chk_reg(`ADDR_CAPTION_LO, 8'h5A);
    chk_reg(`ADDR_CAPTION_HI, 8'hA5);
    pulse(3'b010, 16'h1234);
    chk_reg(`ADDR_STATUS, {3'b001, status_other});
    wr(`ADDR_BLANKING_REQUEST, 8'h00);
    check("zero write", {13'h0000, request}, 16'h0000);
    chk_reg(`ADDR_STATUS, {3'b001, status_other});
    wr(`ADDR_BLANKING_REQUEST, 8'hFE);
    check("request pair", {13'h0000, request}, 16'h0006);
    chk_reg(`ADDR_STATUS, {3'b000, status_other});
    pulse(3'b110, 16'h9876);
    check("pair done", {13'h0000, request}, 16'h0000);
    chk_reg(`ADDR_STATUS, {3'b110, status_other});
    chk_reg(`ADDR_AUX_LO, 8'h76);
    chk_reg(`ADDR_AUX_HI, 8'h98);
    chk_reg(`ADDR_COPY_HI, 8'h98);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_reset_n = 1'b0;
    pixel_in = '0;
    decoded = '0;
    pivot = 1'b0;
    status_other = 5'h15;
    repeat (8) @(posedge clk);
    #2 i_reset_n = 1'b1;
    repeat (4) @(posedge clk);
    #2;
    t_reset();
    t_regs();
    t_video();
    t_skew();
    t_request();
    finish_test();
  end
endmodule
